/* File: include/wspc_map.svh */
/*
 Register offsets, field positions, reset values and port offsets of the
 wavetable serial pin control block.
 Assumes the includer wants plain `define constants.
*/
`ifndef WSPC_MAP_SVH
`define WSPC_MAP_SVH

`define WSPC_PORT_INDEX      3'h3
`define WSPC_PORT_DATA       3'h4
`define WSPC_IDX_RSVD4       8'h04
`define WSPC_IDX_PIN_CTRL    8'h08
`define WSPC_BIT_RESET_FORCE 0
`define WSPC_BIT_CLK_DISABLE 1
`define WSPC_BIT_DSP_SWITCH  2
`define WSPC_BIT_WAVE_EN     3
`define WSPC_CTRL_RESET      4'h0
`define WSPC_CTRL_MASK       8'h0f
`define WSPC_IDX_RESET       8'h00
`define WSPC_GCB_DSP_SWITCH  2
`define WSPC_GCB_WAVE_EN     3

`endif

/* File: include/wspc_pkg.sv */
/*
 Types for the wavetable serial pin control block.
 Assumes the map header is included by each design file that needs numbers.
*/
package wspc_pkg;
	typedef logic [7:0] wspc_byte_type;
	typedef logic [3:0] wspc_ctrl_type;
endpackage

/* File: design/wspc_index_port.sv */
`timescale 1ns/1ps
/*
 Index register of the indirect control register pair.
 Assumes host strobes are one-cycle pulses synchronous to clk.
*/
`include "wspc_map.svh"
module wspc_index_port
	import wspc_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          wr_stb,
	input  wire wspc_byte_type wdata,
	output wspc_byte_type      index_r
);
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			index_r <= `WSPC_IDX_RESET;
		else if (wr_stb)
			index_r <= wdata;
	end
endmodule // wspc_index_port

/* File: design/wspc_pin_router.sv */
`timescale 1ns/1ps
/*
 Shared peripheral pin routing for DSP and wavetable serial ports.
 Assumes control bits are already registered.
*/
`include "wspc_map.svh"
module wspc_pin_router
	import wspc_pkg::*;
(
	input  wire logic       dsp_port_switch,
	input  wire logic       serial_port_enable,
	input  wire logic       wave_port_enable,
	input  wire logic [3:0] periph_low_out,
	input  wire logic [3:0] periph_low_oe,
	input  wire logic [2:0] periph_high_out,
	input  wire logic [2:0] periph_high_oe,
	input  wire logic [3:0] dsp_low_out,
	input  wire logic [3:0] dsp_low_oe,
	input  wire logic [2:0] wave_high_out,
	input  wire logic [2:0] wave_high_oe,
	output logic      [3:0] shared_pins_low_out,
	output logic      [3:0] shared_pins_low_oe,
	output logic      [2:0] shared_pins_high_out,
	output logic      [2:0] shared_pins_high_oe,
	output logic            dsp_on_joystick
);
	wire logic low_is_dsp;
	assign low_is_dsp      = dsp_port_switch | serial_port_enable;
	assign dsp_on_joystick = ~dsp_port_switch;
	assign shared_pins_low_out  = low_is_dsp ? dsp_low_out : periph_low_out;
	assign shared_pins_low_oe   = low_is_dsp ? dsp_low_oe : periph_low_oe;
	assign shared_pins_high_out = wave_port_enable ? wave_high_out : periph_high_out;
	assign shared_pins_high_oe  = wave_port_enable ? wave_high_oe : periph_high_oe;
endmodule // wspc_pin_router

/* File: design/wspc_top.sv */
`timescale 1ns/1ps
/*
 Wavetable serial pin control: indirect register pair, control bits,
 pin routing, synth reset/clock gating, data bus drive suppression.
 Assumes host strobes are one-cycle pulses synchronous to clk, and a
 configuration loader pulses cfg_load once with the global byte.
*/
// Operation
// - Index written at base plus three, data reached at base plus four.
// - Clock disable bit holds synth master clock low.
// - DSP switch moves DSP serial port from joystick to low shared pins.
// - Codec serial port enable converts low shared pins to DSP pins.
// - DSP switch stops data bus drive on peripheral-port accesses.
// - DSP switch also set from global configuration byte.
// - Wave enable converts high shared pins to wavetable serial pins.
// - Wave enable stops data bus drive on peripheral-port accesses.
// - Wave enable also set from global configuration byte.
// - Wave enable remaps codec volume registers to wave volume.
`include "wspc_map.svh"
module wspc_top
	import wspc_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic [2:0]    host_addr,
	input  wire logic          host_sel,
	input  wire logic          host_wr,
	input  wire logic          host_rd,
	input  wire wspc_byte_type host_wdata,
	output wspc_byte_type      host_rdata,
	output logic               host_rdata_oe,
	input  wire logic          periph_access,
	output logic               system_data_bus_oe,
	input  wire logic          cfg_load,
	input  wire wspc_byte_type cfg_global_byte,
	input  wire logic          serial_port_enable,
	input  wire logic          synth_mclk_in,
	output logic               synth_mclk_out,
	output logic               synth_reset_out,
	output logic               wave_volume_remap,
	output logic               dsp_on_joystick,
	input  wire logic [3:0]    periph_low_out,
	input  wire logic [3:0]    periph_low_oe,
	input  wire logic [2:0]    periph_high_out,
	input  wire logic [2:0]    periph_high_oe,
	input  wire logic [3:0]    dsp_low_out,
	input  wire logic [3:0]    dsp_low_oe,
	input  wire logic [2:0]    wave_high_out,
	input  wire logic [2:0]    wave_high_oe,
	output logic      [3:0]    shared_pins_low_out,
	output logic      [3:0]    shared_pins_low_oe,
	output logic      [2:0]    shared_pins_high_out,
	output logic      [2:0]    shared_pins_high_oe
);
	wspc_byte_type index_r;
	wspc_ctrl_type ctrl_r;
	wspc_ctrl_type ctrl_nxt;
	wspc_byte_type rdata_r;
	wspc_byte_type rdata_nxt;
	logic          rd_oe_r;
	wire logic     index_wr;
	wire logic     data_wr;
	wire logic     data_rd;
	wire logic     ctrl_sel;
	wire logic     synth_reset_force;
	wire logic     synth_clock_disable;
	wire logic     dsp_port_switch;
	wire logic     wave_port_enable;
	wire logic     pins_repurposed;

	assign index_wr = host_sel & host_wr & (host_addr == `WSPC_PORT_INDEX);
	assign data_wr  = host_sel & host_wr & (host_addr == `WSPC_PORT_DATA);
	assign data_rd  = host_sel & host_rd & (host_addr == `WSPC_PORT_DATA);
	assign ctrl_sel = (index_r == `WSPC_IDX_PIN_CTRL);

	wspc_index_port u_index
	(
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_stb  (index_wr),
		.wdata   (host_wdata),
		.index_r (index_r)
	);

	assign synth_reset_force   = ctrl_r[`WSPC_BIT_RESET_FORCE];
	assign synth_clock_disable = ctrl_r[`WSPC_BIT_CLK_DISABLE];
	assign dsp_port_switch     = ctrl_r[`WSPC_BIT_DSP_SWITCH];
	assign wave_port_enable    = ctrl_r[`WSPC_BIT_WAVE_EN];

	// Config load ORs in; its set bits win over a host write in the same cycle
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		if (data_wr && ctrl_sel)
			ctrl_nxt = host_wdata[3:0];
		if (cfg_load)
		begin
			ctrl_nxt[`WSPC_BIT_DSP_SWITCH] = ctrl_nxt[`WSPC_BIT_DSP_SWITCH] | cfg_global_byte[`WSPC_GCB_DSP_SWITCH];
			ctrl_nxt[`WSPC_BIT_WAVE_EN] = ctrl_nxt[`WSPC_BIT_WAVE_EN] | cfg_global_byte[`WSPC_GCB_WAVE_EN];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			ctrl_r <= `WSPC_CTRL_RESET;
		else
			ctrl_r <= ctrl_nxt;
	end

	// Reserved and unused indices read zero
	assign rdata_nxt = ctrl_sel ? {4'h0, ctrl_r} : 8'h00;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rdata_r <= 8'h00;
			rd_oe_r <= 1'b0;
		end
		else
		begin
			rdata_r <= data_rd ? rdata_nxt : rdata_r;
			rd_oe_r <= data_rd;
		end
	end
	assign host_rdata    = rdata_r;
	assign host_rdata_oe = rd_oe_r;

	assign synth_reset_out = ~synth_reset_force;
	assign synth_mclk_out  = synth_mclk_in & ~synth_clock_disable;

	assign pins_repurposed    = dsp_port_switch | wave_port_enable;
	assign system_data_bus_oe = periph_access & ~pins_repurposed;

	assign wave_volume_remap = wave_port_enable;

	wspc_pin_router u_router
	(
		.dsp_port_switch      (dsp_port_switch),
		.serial_port_enable   (serial_port_enable),
		.wave_port_enable     (wave_port_enable),
		.periph_low_out       (periph_low_out),
		.periph_low_oe        (periph_low_oe),
		.periph_high_out      (periph_high_out),
		.periph_high_oe       (periph_high_oe),
		.dsp_low_out          (dsp_low_out),
		.dsp_low_oe           (dsp_low_oe),
		.wave_high_out        (wave_high_out),
		.wave_high_oe         (wave_high_oe),
		.shared_pins_low_out  (shared_pins_low_out),
		.shared_pins_low_oe   (shared_pins_low_oe),
		.shared_pins_high_out (shared_pins_high_out),
		.shared_pins_high_oe  (shared_pins_high_oe),
		.dsp_on_joystick      (dsp_on_joystick)
	);
endmodule // wspc_top

/* File: dv/wspc_far.sv */
/* Far-side pin sources and synth clock source.
 Assumes the clock shared with wspc_top. */
`timescale 1ns/1ps
module wspc_far
(
	input  wire logic  clk,
	output logic [3:0] periph_low_out,
	output logic [3:0] periph_low_oe,
	output logic [2:0] periph_high_out,
	output logic [2:0] periph_high_oe,
	output logic [3:0] dsp_low_out,
	output logic [3:0] dsp_low_oe,
	output logic [2:0] wave_high_out,
	output logic [2:0] wave_high_oe,
	output logic       synth_mclk_in
);
	logic [15:0] pat_r = 16'h3c5a;
	// Moves each cycle so stale routing shows
	always @(posedge clk)
		pat_r <= pat_r + 16'h9e37;
	assign {periph_low_out, periph_low_oe, periph_high_out, periph_high_oe, dsp_low_out, dsp_low_oe,
		wave_high_out, wave_high_oe, synth_mclk_in} = {pat_r, ~pat_r[15:3]};
endmodule // wspc_far

/* File: dv/wspc_chk.sv */
/* Port assertions for wspc_top.
 Assumes it is bound into every wspc_top. */
`timescale 1ns/1ps
module wspc_chk
	import wspc_pkg::*;
(
	input wire logic          clk,
	input wire logic          rst_n,
	input wire logic [2:0]    host_addr,
	input wire logic          host_sel,
	input wire logic          host_wr,
	input wire logic          host_rd,
	input wire wspc_byte_type host_wdata,
	input wire logic          host_rdata_oe,
	input wire logic          periph_access,
	input wire logic          system_data_bus_oe,
	input wire logic          cfg_load,
	input wire wspc_byte_type cfg_global_byte,
	input wire logic          synth_mclk_in,
	input wire logic          synth_mclk_out,
	input wire logic          synth_reset_out,
	input wire logic          wave_volume_remap,
	input wire logic          dsp_on_joystick,
	input wire logic [3:0]    dsp_low_out,
	input wire logic [3:0]    shared_pins_low_out
);
	wspc_byte_type idx_r;
	wire wr_c8 = host_sel && host_wr && host_addr == 3'h4 && idx_r == 8'h08;
	// Own copy of the index
	always_ff @(posedge clk)
		idx_r <= !rst_n ? 8'h00 : (host_sel && host_wr && host_addr == 3'h3) ? host_wdata : idx_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_RD_OE: assert property (host_sel && host_rd && host_addr == 3'h4 |=> host_rdata_oe) else $error("no rdata");
	AST_RST_FORCE: assert property (wr_c8 |=> synth_reset_out == !$past(host_wdata[0])) else $error("reset pin");
	AST_WAVE_WR: assert property (wr_c8 && !cfg_load |=> wave_volume_remap == $past(host_wdata[3])) else $error("remap");
	AST_DSP_WR: assert property (wr_c8 && !cfg_load |=> dsp_on_joystick != $past(host_wdata[2])) else $error("dsp");
	AST_CFG_WAVE: assert property (cfg_load && cfg_global_byte[3] |=> wave_volume_remap) else $error("cfg wave");
	AST_CFG_DSP: assert property (cfg_load && cfg_global_byte[2] |=> !dsp_on_joystick) else $error("cfg dsp");
	AST_BUS_OFF: assert property (periph_access && (!dsp_on_joystick || wave_volume_remap) |-> !system_data_bus_oe)
		else $error("bus driven");
	AST_MCLK: assert property (synth_mclk_out |-> synth_mclk_in) else $error("mclk without source");
	AST_MCLK_OFF: assert property (wr_c8 && host_wdata[1] |=> !synth_mclk_out) else $error("mclk not gated");
	AST_LOW_PINS: assert property (!dsp_on_joystick |-> shared_pins_low_out == dsp_low_out) else $error("low pins");
	COV_WR: cover property (wr_c8);
	COV_CFG: cover property (cfg_load ##1 wave_volume_remap);
	COV_RD: cover property (host_rdata_oe);
endmodule // wspc_chk
bind wspc_top wspc_chk u_chk
(
	.clk                 (clk),
	.rst_n               (rst_n),
	.host_addr           (host_addr),
	.host_sel            (host_sel),
	.host_wr             (host_wr),
	.host_rd             (host_rd),
	.host_wdata          (host_wdata),
	.host_rdata_oe       (host_rdata_oe),
	.periph_access       (periph_access),
	.system_data_bus_oe  (system_data_bus_oe),
	.cfg_load            (cfg_load),
	.cfg_global_byte     (cfg_global_byte),
	.synth_mclk_in       (synth_mclk_in),
	.synth_mclk_out      (synth_mclk_out),
	.synth_reset_out     (synth_reset_out),
	.wave_volume_remap   (wave_volume_remap),
	.dsp_on_joystick     (dsp_on_joystick),
	.dsp_low_out         (dsp_low_out),
	.shared_pins_low_out (shared_pins_low_out)
);

/* File: dv/wavetable_serial_pin_control_bench.sv */
/* Self-checking bench for wspc_top.
 Assumes wspc_chk bound and wspc_far driving pin sources. */
`timescale 1ns/1ps
module wavetable_serial_pin_control_bench;
	import wspc_pkg::*;
	logic clk = 0, rst_n = 0, host_sel = 0, host_wr = 0, host_rd = 0, cfg_load = 0, periph_access = 0;
	logic serial_port_enable = 0, host_rdata_oe, system_data_bus_oe, synth_mclk_in, synth_mclk_out;
	logic synth_reset_out, wave_volume_remap, dsp_on_joystick;
	logic [2:0] host_addr = 0, periph_high_out, periph_high_oe, wave_high_out, wave_high_oe;
	logic [2:0] shared_pins_high_out, shared_pins_high_oe;
	logic [3:0] periph_low_out, periph_low_oe, dsp_low_out, dsp_low_oe, shared_pins_low_out, shared_pins_low_oe, c;
	wspc_byte_type host_wdata = 0, cfg_global_byte = 0, host_rdata;
	logic [31:0] lfsr = 32'h9faf;
	int mismatches = 0, n_tests = 0, cyc = 0;
	wire [18:0] outs = {synth_reset_out, synth_mclk_out, dsp_on_joystick, wave_volume_remap, system_data_bus_oe,
		shared_pins_low_out, shared_pins_low_oe, shared_pins_high_out, shared_pins_high_oe};
	wspc_top uut(.*);
	wspc_far u_far(.*);
	always #50 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		// Whole run needs about 260 cycles
		if (cyc == 3000)
		begin
			mismatches++;
			end_sim();
		end
	end
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [18:0] expo(input logic [3:0] k);
		return {!k[0], synth_mclk_in & !k[1], !k[2], k[3], periph_access & !(k[2] | k[3]),
			(k[2] | serial_port_enable) ? {dsp_low_out, dsp_low_oe} : {periph_low_out, periph_low_oe},
			k[3] ? {wave_high_out, wave_high_oe} : {periph_high_out, periph_high_oe}};
	endfunction
	task automatic chk(input logic [18:0] seen, input logic [18:0] exp, input string what);
		n_tests++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Idle cycle first, so strobes never toggle twice in one step
	task automatic acc(input logic [2:0] a, input wspc_byte_type d, input logic rd);
		@(posedge clk) #1;
		{host_sel, host_wr, host_rd, host_addr, host_wdata} = {1'b1, !rd, rd, a, d};
		@(posedge clk) #1;
		{host_sel, host_wr, host_rd} = 3'h0;
	endtask
	task automatic rd8(input wspc_byte_type exp);
		acc(3'h4, 8'h00, 1'b1);
		chk({host_rdata_oe, host_rdata}, {1'b1, exp}, "read data");
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		#1 rst_n = 1;
		for (int r = 0; r < 2; r++)
		begin
			chk(outs, expo(4'h0), "reset state");
			acc(3'h3, 8'h08, 1'b0);
			rd8(8'h00);
			for (int i = 0; i < 24; i++)
			begin
				lfsr = nx(lfsr);
				c = (i < 4) ? 4'h1 << i : lfsr[3:0];
				periph_access = lfsr[4];
				serial_port_enable = lfsr[5];
				acc(3'h4, {4'h0, c}, 1'b0);
				chk(outs, expo(c), "pin routing");
				rd8({4'h0, c});
			end
			acc(3'h4, 8'h05, 1'b0);
			acc(3'h3, 8'h04, 1'b0);
			acc(3'h4, 8'h00, 1'b0);
			rd8(8'h00);
			acc(3'h3, 8'h08, 1'b0);
			rd8(8'h05);
			acc(3'h4, 8'h00, 1'b0);
			for (int j = 0; j < 3; j++)
			begin
				@(posedge clk) #1;
				{cfg_load, cfg_global_byte} = {1'b1, (j == 0) ? 8'hf3 : (j == 1) ? 8'h04 : 8'h08};
				@(posedge clk) #1;
				cfg_load = 0;
				chk(outs, expo((j == 0) ? 4'h0 : (j == 1) ? 4'h4 : 4'hc), "config byte");
			end
			$display("test pass %0d finished", r);
			rst_n = 0;
			@(posedge clk) #1;
			rst_n = 1;
		end
		end_sim();
	end
endmodule // wavetable_serial_pin_control_bench
